// ---- design/ssfc_cfg.svh ----
// constants of the serial slave port with ready flow control
// Functional notes
// - header 0x81 makes a read transaction
// - header 0x42 writes payload into receive buffer
// - header bytes return general then capacity status
// - general status byte is 0xC0 when ready
// - write: capacity is free receive space
// - read: capacity is bytes waiting to send
// - ready drops at select, rises when set
// - select high: ready shows data waiting
// - until first byte: ready means port ready
// - after first byte: ready means buffer ready
// - select rise ends transaction at any time
// - clock idles low, sampled on rising edge
// - each buffer holds 64 bytes
`ifndef SSFC_CFG_SVH
`define SSFC_CFG_SVH
`define SSFC_CTRL_READ 8'h81
`define SSFC_CTRL_WRITE 8'h42
`define SSFC_GENERAL_STATUS_BYTE_READY 8'hC0
`define SSFC_ZERO_BYTE 8'h00
`define SSFC_DEPTH 64
`define SSFC_BIT_FIRST 3'h0
`define SSFC_BIT_LAST 3'h7
`define SSFC_IDX_CTRL 2'h0
`define SSFC_IDX_FILL 2'h1
`define SSFC_IDX_PAY 2'h2
`define SSFC_SYNC_INIT 3'h4
`endif

// ---- design/ssfc_pkg.sv ----
// types shared by the serial slave port
`include "ssfc_cfg.svh"
package ssfc_pkg;
    typedef enum logic [1:0] {
        XFER_NONE = 2'b00,
        XFER_READ = 2'b01,
        XFER_WRITE = 2'b10
    } ssfc_xfer_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SNAP = 2'b01,
        ST_HEAD = 2'b10,
        ST_BODY = 2'b11
    } ssfc_state_t;
    typedef struct packed {
        logic [7:0] rxFree;
        logic [7:0] txCount;
    } ssfc_snap_t;
    function automatic ssfc_xfer_t ssfc_decode(input logic [7:0] ctrl);
        if (ctrl == `SSFC_CTRL_READ) return XFER_READ;
        if (ctrl == `SSFC_CTRL_WRITE) return XFER_WRITE;
        return XFER_NONE;
    endfunction
endpackage

// ---- design/ssfc_sync.sv ----
// two-stage level synchroniser
`timescale 1ns/1ps
module ssfc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1 <= INIT;
            dout <= INIT;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule // ssfc_sync

// ---- design/ssfc_fifo.sv ----
// byte buffer in flip-flops with valid/ready on both sides
`timescale 1ns/1ps
`include "ssfc_cfg.svh"
module ssfc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `SSFC_DEPTH,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady,
    output logic [AW:0] count
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    wire push = inValid && inReady;
    wire pop = outValid && outReady;
    wire [AW-1:0] lastPtr = AW'(DEPTH - 1);
    wire [AW-1:0] next_wrPtr = (wrPtr == lastPtr) ? '0 : wrPtr + 1'b1;
    wire [AW-1:0] next_rdPtr = (rdPtr == lastPtr) ? '0 : rdPtr + 1'b1;
    wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign inReady = count != (AW + 1)'(DEPTH);
    assign outValid = count != '0;
    assign outData = mem[rdPtr];
    always_ff @(posedge clk) begin
        if (push) mem[wrPtr] <= inData;
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (push) wrPtr <= next_wrPtr;
            if (pop) rdPtr <= next_rdPtr;
            count <= next_count;
        end
    end
endmodule // ssfc_fifo

// ---- design/ssfc_slave.sv ----
// serial slave port with ready flow control, link side on the serial clock
`timescale 1ns/1ps
`include "ssfc_cfg.svh"
module ssfc_slave #(
    parameter int DEPTH = `SSFC_DEPTH
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sck,
    input wire logic chip_select_n,
    input wire logic mosi,
    output logic miso,
    output logic rdy,
    output logic [7:0] rxData,
    output logic rxValid,
    input wire logic rxReady,
    input wire logic [7:0] txData,
    input wire logic txValid,
    output logic txReady
);
    localparam int CW = $clog2(DEPTH) + 1;

    // ---------------- link domain (serial clock) ----------------
    // select high clears the frame logic; the clock is stopped then
    wire frameRst = !arst_n || chip_select_n;
    logic [2:0] bitCnt;
    logic [1:0] byteIdx;
    logic [7:0] shiftIn;
    logic [7:0] shiftOut;
    logic [7:0] rxHold;
    logic byteToggle;
    logic loadToggle;
    ssfc_pkg::ssfc_xfer_t linkXfer;
    // written by the clk domain only while rdy is low or the frame is idle
    ssfc_pkg::ssfc_snap_t snap;
    logic [7:0] txHold;

    wire [7:0] inByte = {shiftIn[6:0], mosi};
    wire byteEnd = bitCnt == `SSFC_BIT_LAST;
    wire atPay = byteIdx == `SSFC_IDX_PAY;
    wire [1:0] next_byteIdx = atPay ? byteIdx : byteIdx + 2'h1;

    always_ff @(posedge sck or posedge frameRst) begin
        if (frameRst) begin
            bitCnt <= `SSFC_BIT_FIRST;
            byteIdx <= `SSFC_IDX_CTRL;
            shiftIn <= `SSFC_ZERO_BYTE;
            linkXfer <= ssfc_pkg::XFER_NONE;
        end else begin
            shiftIn <= inByte;
            bitCnt <= bitCnt + 3'h1;
            if (byteEnd) byteIdx <= next_byteIdx;
            if (byteEnd && byteIdx == `SSFC_IDX_CTRL) begin
                linkXfer <= ssfc_pkg::ssfc_decode(inByte);
            end
        end
    end

    // toggles survive the frame reset so no false event appears at select
    always_ff @(posedge sck or negedge arst_n) begin
        if (!arst_n) begin
            rxHold <= `SSFC_ZERO_BYTE;
            byteToggle <= 1'b0;
        end else if (byteEnd) begin
            rxHold <= inByte;
            byteToggle <= !byteToggle;
        end
    end

    wire isRead = linkXfer == ssfc_pkg::XFER_READ;
    wire isWrite = linkXfer == ssfc_pkg::XFER_WRITE;
    wire [7:0] capByte = isWrite ? snap.rxFree : (isRead ? snap.txCount : `SSFC_ZERO_BYTE);
    wire [7:0] payByte = isRead ? txHold : `SSFC_ZERO_BYTE;
    wire loadSlot = bitCnt == `SSFC_BIT_FIRST && byteIdx != `SSFC_IDX_CTRL;
    wire [7:0] loadByte = (byteIdx == `SSFC_IDX_FILL) ? capByte : payByte;
    wire loadTx = loadSlot && atPay && isRead;

    // data changes on the falling edge so it is stable at the rising edge
    always_ff @(negedge sck or posedge frameRst) begin
        if (frameRst) begin
            shiftOut <= `SSFC_GENERAL_STATUS_BYTE_READY;
        end else if (loadSlot) begin
            shiftOut <= loadByte;
        end else begin
            shiftOut <= {shiftOut[6:0], 1'b0};
        end
    end

    always_ff @(negedge sck or negedge arst_n) begin
        if (!arst_n) begin
            loadToggle <= 1'b0;
        end else if (loadTx) begin
            loadToggle <= !loadToggle;
        end
    end

    assign miso = shiftOut[7];

    a_general_status_byte_first: assert property (@(posedge sck) disable iff (frameRst)
        (byteIdx == `SSFC_IDX_CTRL && bitCnt == `SSFC_BIT_FIRST) |-> shiftOut == `SSFC_GENERAL_STATUS_BYTE_READY)
        else $error("general status byte not presented at frame start");
    a_buffer_capacity_byte_cap: assert property (@(posedge sck) disable iff (frameRst)
        (byteIdx == `SSFC_IDX_FILL && bitCnt == `SSFC_BIT_FIRST) |-> shiftOut == capByte)
        else $error("capacity byte does not match the snapshot");

    // ---------------- system domain ----------------
    logic [2:0] syncOut;
    ssfc_sync #(
        .WIDTH(3),
        .INIT(`SSFC_SYNC_INIT)
    ) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .din({chip_select_n, byteToggle, loadToggle}),
        .dout(syncOut)
    );

    logic byteTogSeen;
    logic loadTogSeen;
    wire csHigh = syncOut[2];
    wire byteEvent = syncOut[1] != byteTogSeen;
    wire loadEvent = syncOut[0] != loadTogSeen;

    ssfc_pkg::ssfc_state_t state;
    ssfc_pkg::ssfc_state_t next_state;
    ssfc_pkg::ssfc_xfer_t hostXfer;
    logic hdrDone;
    logic txFresh;
    logic [CW-1:0] rxCount;
    logic [CW-1:0] txCount;
    logic rxInReady;
    logic txOutValid;
    logic [7:0] txHead;

    wire inBody = state == ssfc_pkg::ST_BODY;
    wire wrFrame = inBody && hostXfer == ssfc_pkg::XFER_WRITE;
    wire rdFrame = inBody && hostXfer == ssfc_pkg::XFER_READ;
    // filler byte is never stored; unknown headers touch nothing
    wire rxPush = byteEvent && wrFrame && hdrDone;
    wire txPop = loadEvent && rdFrame;
    wire txRefresh = rdFrame && !txFresh && txOutValid && !rdy;
    wire [7:0] txNext = txOutValid ? txHead : `SSFC_ZERO_BYTE;
    wire [7:0] next_rxFree = 8'(DEPTH) - 8'(rxCount);
    wire bodyRdy = wrFrame ? (rxInReady && !byteEvent) : (rdFrame ? (txFresh && !loadEvent) : 1'b0);
    wire next_rdy = csHigh ? txOutValid :
        ((state == ssfc_pkg::ST_HEAD) ? !byteEvent : (inBody ? bodyRdy : 1'b0));

    always_comb begin
        next_state = state;
        unique case (state)
            ssfc_pkg::ST_IDLE: if (!csHigh) next_state = ssfc_pkg::ST_SNAP;
            ssfc_pkg::ST_SNAP: next_state = ssfc_pkg::ST_HEAD;
            ssfc_pkg::ST_HEAD: if (byteEvent) next_state = ssfc_pkg::ST_BODY;
            ssfc_pkg::ST_BODY: next_state = ssfc_pkg::ST_BODY;
        endcase
        if (csHigh) next_state = ssfc_pkg::ST_IDLE;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ssfc_pkg::ST_IDLE;
            rdy <= 1'b0;
            byteTogSeen <= 1'b0;
            loadTogSeen <= 1'b0;
        end else begin
            state <= next_state;
            rdy <= next_rdy;
            byteTogSeen <= syncOut[1];
            loadTogSeen <= syncOut[0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hostXfer <= ssfc_pkg::XFER_NONE;
            hdrDone <= 1'b0;
        end else if (state == ssfc_pkg::ST_SNAP) begin
            hostXfer <= ssfc_pkg::XFER_NONE;
            hdrDone <= 1'b0;
        end else if (byteEvent && state == ssfc_pkg::ST_HEAD) begin
            hostXfer <= ssfc_pkg::ssfc_decode(rxHold);
        end else if (byteEvent && inBody) begin
            hdrDone <= 1'b1;
        end
    end

    // snapshot is frozen while rdy is high, so the link side reads it unsynchronised
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            snap <= '0;
            txHold <= `SSFC_ZERO_BYTE;
            txFresh <= 1'b0;
        end else if (state == ssfc_pkg::ST_SNAP) begin
            snap.rxFree <= next_rxFree;
            snap.txCount <= 8'(txCount);
            txHold <= txNext;
            txFresh <= txOutValid;
        end else if (txPop) begin
            txFresh <= 1'b0;
        end else if (txRefresh) begin
            txHold <= txNext;
            txFresh <= 1'b1;
        end
    end

    // an overflowing write byte is dropped; the capacity byte warned the master
    ssfc_fifo #(
        .WIDTH(8),
        .DEPTH(DEPTH)
    ) u_rxbuf (
        .clk(clk),
        .arst_n(arst_n),
        .inData(rxHold),
        .inValid(rxPush),
        .inReady(rxInReady),
        .outData(rxData),
        .outValid(rxValid),
        .outReady(rxReady),
        .count(rxCount)
    );

    ssfc_fifo #(
        .WIDTH(8),
        .DEPTH(DEPTH)
    ) u_txbuf (
        .clk(clk),
        .arst_n(arst_n),
        .inData(txData),
        .inValid(txValid),
        .inReady(txReady),
        .outData(txHead),
        .outValid(txOutValid),
        .outReady(txPop),
        .count(txCount)
    );

    a_cs_fall_low: assert property (@(posedge clk) disable iff (!arst_n)
        (state == ssfc_pkg::ST_IDLE && !csHigh) |=> !rdy ##1 (!rdy || csHigh))
        else $error("rdy not low after select fell");
    a_head_rdy_rise: assert property (@(posedge clk) disable iff (!arst_n)
        (state == ssfc_pkg::ST_SNAP && !csHigh) ##1 (!csHigh && !byteEvent) |=> rdy)
        else $error("rdy did not rise for the header");
    a_idle_data: assert property (@(posedge clk) disable iff (!arst_n)
        csHigh |=> rdy == $past(txOutValid))
        else $error("idle rdy does not show pending send data");
    a_full_hold: assert property (@(posedge clk) disable iff (!arst_n)
        (wrFrame && !rxInReady && !csHigh) |=> !rdy)
        else $error("rdy high with receive buffer full");
    a_byte_hold: assert property (@(posedge clk) disable iff (!arst_n)
        (rdFrame && loadEvent && !csHigh) |=> !rdy)
        else $error("rdy not lowered after a read byte");
    a_wr_store: assert property (@(posedge clk) disable iff (!arst_n)
        (rxPush && rxInReady && !(rxValid && rxReady)) |=> rxCount == $past(rxCount) + 1'b1)
        else $error("write payload byte not stored");
    a_rd_take: assert property (@(posedge clk) disable iff (!arst_n)
        (txPop && txOutValid && !(txValid && txReady)) |=> txCount == $past(txCount) - 1'b1)
        else $error("read payload byte not taken");
    a_bad_hdr: assert property (@(posedge clk) disable iff (!arst_n)
        (inBody && hostXfer == ssfc_pkg::XFER_NONE) |-> !rxPush && !txPop)
        else $error("buffer touched after unknown header");
    a_snap_cap: assert property (@(posedge clk) disable iff (!arst_n)
        state == ssfc_pkg::ST_SNAP |=> snap.rxFree == 8'(DEPTH) - 8'($past(rxCount)))
        else $error("receive capacity snapshot wrong");
endmodule // ssfc_slave

// ---- bench/ssfc_master_model.sv ----
// serial master model: frames, bytes and ready polling on the link side
`timescale 1ns/1ps
module ssfc_master_model (
    output logic sck,
    output logic chip_select_n,
    output logic mosi,
    input wire logic miso,
    input wire logic rdy
);
    initial begin
        sck = 1'b0;
        chip_select_n = 1'b1;
        mosi = 1'b1;
    end

    // bounded so a stuck ready line cannot hang the run
    task automatic wait_rdy();
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 100) begin
            #10;
            n++;
        end
    endtask

    task automatic open_frame(output logic early, output logic late);
        chip_select_n = 1'b0;
        // rdy is low from 30 ns until at least 40 ns after select, whatever the clock phase
        #35 early = rdy;
        #65 wait_rdy();
        late = rdy;
    endtask

    // clock runs only inside frames, 6 ns period
    task automatic xfer(input logic [7:0] tx, input bit flow, output logic [7:0] rx);
        if (flow) begin
            #60 wait_rdy();
        end
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #3 sck = 1'b1;
            rx[i] = miso;
            #3 sck = 1'b0;
        end
        // line released: show the inverse so no stale value looks valid
        mosi = ~mosi;
    endtask

    task automatic close_frame();
        #3 chip_select_n = 1'b1;
        #50;
    endtask
endmodule // ssfc_master_model

// ---- bench/spi_slave_flow_control_tb_top.sv ----
// self-checking bench of the serial slave port
`timescale 1ns/1ps
module spi_slave_flow_control_tb_top;
    logic clk, arst_n, sck, chip_select_n, mosi, miso, rdy;
    logic [7:0] rxData, txData, got;
    logic rxValid, rxReady, txValid, txReady, early, late;
    logic [7:0] expQ[$];
    int numErrors = 0;
    int samplesChecked = 0;
    int cycles = 0;

    ssfc_slave i_ssfc_slave (.clk(clk), .arst_n(arst_n), .sck(sck),
        .chip_select_n(chip_select_n), .mosi(mosi), .miso(miso), .rdy(rdy),
        .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
        .txData(txData), .txValid(txValid), .txReady(txReady));
    ssfc_master_model i_ssfc_master_model (.sck(sck), .chip_select_n(chip_select_n),
        .mosi(mosi), .miso(miso), .rdy(rdy));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic finish_test();
        $display("errors %0d checks %0d", numErrors, samplesChecked);
        if (numErrors == 0 && samplesChecked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            numErrors++;
            finish_test();
        end
    end

    task automatic check8(input logic [7:0] g, input logic [7:0] e);
        samplesChecked++;
        if (g !== e) begin
            numErrors++;
            $display("BAD %0t byte %h expected %h", $time, g, e);
        end
    endtask

    task automatic check1(input logic g, input logic e);
        samplesChecked++;
        if (g !== e) begin
            numErrors++;
            $display("BAD %0t flag %b expected %b", $time, g, e);
        end
    endtask

    task automatic head(input logic [7:0] ctrl, input bit flow, input logic [7:0] cap);
        logic [7:0] s1, s2;
        i_ssfc_master_model.open_frame(early, late);
        check1(early, 1'b0);
        check1(late, 1'b1);
        i_ssfc_master_model.xfer(ctrl, 1'b0, s1);
        i_ssfc_master_model.xfer(8'h00, flow, s2);
        check8(s1, 8'hC0);
        check8(s2, cap);
    endtask

    task automatic drain();
        int n;
        while (expQ.size() > 0) begin
            @(negedge clk);
            n = 0;
            while (rxValid !== 1'b1 && n < 50) begin
                @(negedge clk);
                n++;
            end
            check8(rxData, expQ.pop_front());
            @(posedge clk) rxReady <= 1'b1;
            @(posedge clk) rxReady <= 1'b0;
        end
    endtask

    task automatic t_reset();
        #1;
        check1(rdy, 1'b0);
        check1(miso, 1'b1);
        check1(rxValid, 1'b0);
        check1(txReady, 1'b1);
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (8) @(posedge clk);
        check1(rdy, 1'b0);
    endtask

    task automatic t_write_flow();
        head(8'h42, 1'b1, 8'h40);
        foreach (expQ[i]) i_ssfc_master_model.xfer(expQ[i], 1'b1, got);
        i_ssfc_master_model.close_frame();
        drain();
    endtask

    // blind master sends exactly the reported capacity, then a status-only query
    task automatic t_fill();
        head(8'h42, 1'b1, 8'h40);
        for (int i = 0; i < 64; i++) begin
            expQ.push_back(8'(i + 16));
            i_ssfc_master_model.xfer(8'(i + 16), 1'b0, got);
        end
        i_ssfc_master_model.close_frame();
        head(8'h42, 1'b0, 8'h00);
        #80 check1(rdy, 1'b0);
        i_ssfc_master_model.close_frame();
        drain();
    endtask

    task automatic t_read();
        logic [7:0] d[3] = '{8'h11, 8'h22, 8'h33};
        foreach (d[i]) begin
            @(posedge clk);
            txValid <= 1'b1;
            txData <= d[i];
        end
        @(posedge clk) txValid <= 1'b0;
        repeat (8) @(posedge clk);
        check1(rdy, 1'b1);
        head(8'h81, 1'b1, 8'h03);
        foreach (d[i]) begin
            i_ssfc_master_model.xfer(8'h00, 1'b1, got);
            check8(got, d[i]);
        end
        #80 check1(rdy, 1'b0);
        i_ssfc_master_model.close_frame();
        #60 check1(rdy, 1'b0);
    endtask

    task automatic t_unknown();
        head(8'h55, 1'b0, 8'h00);
        i_ssfc_master_model.xfer(8'hAA, 1'b0, got);
        i_ssfc_master_model.xfer(8'h5A, 1'b0, got);
        #80 check1(rdy, 1'b0);
        i_ssfc_master_model.close_frame();
        repeat (10) @(posedge clk);
        check1(rxValid, 1'b0);
    endtask

    initial begin
        arst_n = 1'b0;
        rxReady = 1'b0;
        txData = 8'h00;
        txValid = 1'b0;
        t_reset();
        expQ = '{8'hA5, 8'h5A, 8'h3C};
        t_write_flow();
        t_fill();
        t_read();
        t_unknown();
        finish_test();
    end
endmodule // spi_slave_flow_control_tb_top
